// File: core/tmr_pkg.sv
// constants shared by the timer block
package tmr_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_CNT_LO   = 8'h04;
    localparam logic [7:0] OFF_CNT_HI   = 8'h08;
    localparam logic [7:0] OFF_RL_LO    = 8'h0C;
    localparam logic [7:0] OFF_RL_HI    = 8'h10;
    localparam logic [7:0] OFF_CLK_CTL  = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h18;
    // control register fields
    localparam int BIT_HI_FLAG   = 7;
    localparam int BIT_LO_FLAG   = 6;
    localparam int BIT_LO_IRQ_EN = 5;
    localparam int BIT_CAPTURE   = 4;
    localparam int BIT_SPLIT     = 3;
    localparam int BIT_RUN       = 2;
    localparam int BIT_XCLK      = 0;
    localparam logic [5:0] CTL_WR_MASK = 6'h3D;
    // clock control fields
    localparam int BIT_HI_CLK_SEL = 7;
    localparam int BIT_LO_CLK_SEL = 6;
    // reset values and counts
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [3:0] PRESCALE_LAST = 4'hB;
    localparam logic [2:0] EXT_DIV_LAST  = 3'h7;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OFF_CONTROL) || (a == OFF_CNT_LO) ||
               (a == OFF_CNT_HI) || (a == OFF_RL_LO) ||
               (a == OFF_RL_HI) || (a == OFF_CLK_CTL) ||
               (a == OFF_IRQ_EN);
    endfunction

    function automatic logic byte_wraps(input logic [7:0] b);
        return b == 8'hFF;
    endfunction
endpackage

// File: core/tmr_ifs.sv
// interfaces between the timer's own modules
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic sys12_tick;
    logic ext8_fall;
    modport src  (output sys12_tick, output ext8_fall);
    modport sink (input sys12_tick, input ext8_fall);
endinterface

interface reg_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport master (output wr_en, output wr_addr, output wr_data,
                    output rd_addr, input rd_data);
    modport regs   (input wr_en, input wr_addr, input wr_data,
                    input rd_addr, output rd_data);
endinterface
`default_nettype wire

// File: core/tick_gen.sv
// count-source ticks: system clock /12 and external oscillator /8
`timescale 1ns/1ps
`default_nettype none
module tick_gen (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // external oscillator
    input  wire logic ext_osc,
    // ticks
    tick_if.src       tk
);
    logic [3:0] pre_r;
    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic [2:0] ediv_r;

    wire ext_rise = sync2_r & ~prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_r   <= 4'h0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            ediv_r  <= 3'h0;
        end else begin
            pre_r   <= (pre_r == tmr_pkg::PRESCALE_LAST) ? 4'h0
                                                         : pre_r + 4'h1;
            sync1_r <= ext_osc;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            if (ext_rise) begin
                ediv_r <= ediv_r + 3'h1;
            end
        end
    end

    assign tk.sys12_tick = (pre_r == tmr_pkg::PRESCALE_LAST);
    assign tk.ext8_fall  = ext_rise & (ediv_r == tmr_pkg::EXT_DIV_LAST);

    a_prescale_gap: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tk.sys12_tick |=> (!tk.sys12_tick)[*8] ##1 (!tk.sys12_tick)[*3]
        ##1 tk.sys12_tick)
        else $error("divide-by-12 tick spacing wrong");

    a_ext_spacing: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tk.ext8_fall |-> $past(sync1_r) && !$past(sync1_r, 2)
        ##1 (!tk.ext8_fall)[*8])
        else $error("oscillator /8 event too close");
endmodule
`default_nettype wire

// File: core/axil_slave.sv
// AXI4-Lite slave front end for the timer registers
`timescale 1ns/1ps
`default_nettype none
module axil_slave (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address and data
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // register side
    reg_if.master            rg
);
    logic       aw_full_r;
    logic [7:0] aw_addr_r;
    logic       w_full_r;
    logic [7:0] w_data_r;
    logic       w_lane_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       rvalid_r;
    logic [7:0] rdata_r;
    logic [1:0] rresp_r;

    wire do_wr   = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_hit  = tmr_pkg::is_mapped(aw_addr_r);
    wire rd_take = arvalid & ~rvalid_r;

    assign awready    = ~aw_full_r;
    assign wready     = ~w_full_r;
    assign arready    = ~rvalid_r;
    assign bvalid     = bvalid_r;
    assign bresp      = bresp_r;
    assign rvalid     = rvalid_r;
    assign rresp      = rresp_r;
    assign rdata      = {24'h000000, rdata_r};
    assign rg.wr_en   = do_wr & wr_hit & w_lane_r;
    assign rg.wr_addr = aw_addr_r;
    assign rg.wr_data = w_data_r;
    assign rg.rd_addr = araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_full_r  <= 1'b0;
            w_data_r  <= 8'h00;
            w_lane_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= tmr_pkg::RESP_OKAY;
        end else begin
            if (do_wr) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? tmr_pkg::RESP_OKAY
                                    : tmr_pkg::RESP_SLVERR;
            end else begin
                if (awvalid && !aw_full_r) begin
                    aw_full_r <= 1'b1;
                    aw_addr_r <= awaddr;
                end
                if (wvalid && !w_full_r) begin
                    w_full_r <= 1'b1;
                    w_data_r <= wdata[7:0];
                    w_lane_r <= wstrb[0];
                end
                if (bready) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 8'h00;
            rresp_r  <= tmr_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rg.rd_data;
            rresp_r  <= tmr_pkg::is_mapped(araddr) ? tmr_pkg::RESP_OKAY
                                                   : tmr_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: core/auto_reload_timer_with_capture.sv
// 16-bit / split 8-bit auto-reload timer with oscillator capture
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 16-bit counter or two 8-bit timers
// - sources: clock, clock/12, oscillator/8
// - oscillator source synchronised before counting
// - 16-bit overflow loads both reload bytes
// - 16-bit overflow sets high flag
// - interrupt on every 16-bit overflow
// - optional interrupt on low byte wrap
// - split: each byte reloads on own wrap
// - split: run bit gates high byte only
// - per-byte select: clock, else /12 or /8
// - split: each byte wrap sets its flag
// - split: interrupt on high, optionally either
// - flags stay until software clears them
// - capture counts low byte on clock or clock/12
// - capture copies count into reload, sets flag
// - capture on oscillator/8 falling edge
// - capture enable bit selects capture mode
// - low flag on every low wrap
module auto_reload_timer_with_capture (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi write address and data
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // external oscillator and interrupt request
    input  wire logic        ext_osc,
    output logic             irq_request
);
    //--------------------------------------------------------------
    // sub-blocks
    //--------------------------------------------------------------
    tick_if tk ();
    reg_if  rg ();

    tick_gen u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ext_osc (ext_osc),
        .tk      (tk.src)
    );

    axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rg      (rg.master)
    );

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_hi_r;
    logic [7:0] rl_lo_r;
    logic [7:0] rl_hi_r;
    logic [5:0] ctl_r;
    logic       hi_flag_r;
    logic       lo_flag_r;
    logic [1:0] clk_ctl_r;
    logic       irq_en_r;

    function automatic logic [7:0] advance(input logic [7:0] b,
                                           input logic [7:0] rl,
                                           input logic       wrap);
        return wrap ? rl : b + 8'h01;
    endfunction

    //--------------------------------------------------------------
    // write decode and field names
    //--------------------------------------------------------------
    wire wr_ctl    = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_CONTROL);
    wire wr_cnt_lo = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_CNT_LO);
    wire wr_cnt_hi = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_CNT_HI);
    wire wr_rl_lo  = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_RL_LO);
    wire wr_rl_hi  = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_RL_HI);
    wire wr_clk    = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_CLK_CTL);
    wire wr_irq    = rg.wr_en && (rg.wr_addr == tmr_pkg::OFF_IRQ_EN);

    wire low_byte_irq_enable   = ctl_r[tmr_pkg::BIT_LO_IRQ_EN];
    wire capture_mode_enable   = ctl_r[tmr_pkg::BIT_CAPTURE];
    wire split_mode_select     = ctl_r[tmr_pkg::BIT_SPLIT];
    wire run_control           = ctl_r[tmr_pkg::BIT_RUN];
    wire external_clock_select = ctl_r[tmr_pkg::BIT_XCLK];
    wire high_clock_select     = clk_ctl_r[1];
    wire low_clock_select      = clk_ctl_r[0];

    //--------------------------------------------------------------
    // count sources
    //--------------------------------------------------------------
    // per-byte source choice
    wire ext_or_div_hi = external_clock_select ? tk.ext8_fall
                                               : tk.sys12_tick;
    // capture never counts the low byte on the measured source
    wire ext_or_div_lo = (external_clock_select && !capture_mode_enable)
                         ? tk.ext8_fall : tk.sys12_tick;
    wire tick_hi = high_clock_select | ext_or_div_hi;
    wire tick_lo = low_clock_select | ext_or_div_lo;

    //--------------------------------------------------------------
    // counting events
    //--------------------------------------------------------------
    // mode decode
    wire split    = split_mode_select;
    wire step16   = !split && run_control && tick_lo;
    wire lo_full  = tmr_pkg::byte_wraps(cnt_lo_r);
    wire hi_full  = tmr_pkg::byte_wraps(cnt_hi_r);
    wire wrap16   = step16 && lo_full && hi_full;
    // low byte free-running in split mode
    wire lo_step  = split ? tick_lo : step16;
    wire lo_wrap  = lo_step && lo_full;
    wire hi_step_s = split && run_control && tick_hi;
    wire hi_wrap_s = hi_step_s && hi_full;
    wire hi_adv   = split ? hi_step_s : (step16 && lo_full);
    wire hi_load  = split ? hi_wrap_s : wrap16;
    wire lo_load  = split ? lo_wrap : wrap16;
    // captured on oscillator /8 falling edge
    wire capture_evt = capture_mode_enable && run_control &&
                       tk.ext8_fall;
    wire hi_event = wrap16 || hi_wrap_s || capture_evt;

    //--------------------------------------------------------------
    // next values
    //--------------------------------------------------------------
    wire [7:0] cnt_lo_nxt = wr_cnt_lo ? rg.wr_data :
        lo_step ? advance(cnt_lo_r, rl_lo_r, lo_load) : cnt_lo_r;
    wire [7:0] cnt_hi_nxt = wr_cnt_hi ? rg.wr_data :
        hi_adv ? advance(cnt_hi_r, rl_hi_r, hi_load) : cnt_hi_r;
    wire [7:0] rl_lo_nxt = capture_evt ? cnt_lo_r :
                           wr_rl_lo ? rg.wr_data : rl_lo_r;
    wire [7:0] rl_hi_nxt = capture_evt ? cnt_hi_r :
                           wr_rl_hi ? rg.wr_data : rl_hi_r;
    wire hi_flag_nxt = hi_event ||
        (wr_ctl ? rg.wr_data[tmr_pkg::BIT_HI_FLAG] : hi_flag_r);
    wire lo_flag_nxt = lo_wrap ||
        (wr_ctl ? rg.wr_data[tmr_pkg::BIT_LO_FLAG] : lo_flag_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_lo_r  <= tmr_pkg::RESET_BYTE;
            cnt_hi_r  <= tmr_pkg::RESET_BYTE;
            rl_lo_r   <= tmr_pkg::RESET_BYTE;
            rl_hi_r   <= tmr_pkg::RESET_BYTE;
            ctl_r     <= 6'h00;
            hi_flag_r <= 1'b0;
            lo_flag_r <= 1'b0;
            clk_ctl_r <= 2'h0;
            irq_en_r  <= 1'b0;
        end else begin
            cnt_lo_r  <= cnt_lo_nxt;
            cnt_hi_r  <= cnt_hi_nxt;
            rl_lo_r   <= rl_lo_nxt;
            rl_hi_r   <= rl_hi_nxt;
            hi_flag_r <= hi_flag_nxt;
            lo_flag_r <= lo_flag_nxt;
            if (wr_ctl) begin
                ctl_r <= rg.wr_data[5:0] & tmr_pkg::CTL_WR_MASK;
            end
            if (wr_clk) begin
                clk_ctl_r <= {rg.wr_data[tmr_pkg::BIT_HI_CLK_SEL],
                              rg.wr_data[tmr_pkg::BIT_LO_CLK_SEL]};
            end
            if (wr_irq) begin
                irq_en_r <= rg.wr_data[0];
            end
        end
    end

    //--------------------------------------------------------------
    // interrupt request and read mux
    //--------------------------------------------------------------
    // high flag requests whenever irq_en_r is set
    assign irq_request = irq_en_r &&
        (hi_flag_r || (low_byte_irq_enable && lo_flag_r));

    wire [7:0] ctl_view = {hi_flag_r, lo_flag_r, ctl_r};
    wire [7:0] clk_view = {clk_ctl_r, 6'h00};
    wire [7:0] a = rg.rd_addr;
    assign rg.rd_data =
        (a == tmr_pkg::OFF_CONTROL) ? ctl_view :
        (a == tmr_pkg::OFF_CNT_LO)  ? cnt_lo_r :
        (a == tmr_pkg::OFF_CNT_HI)  ? cnt_hi_r :
        (a == tmr_pkg::OFF_RL_LO)   ? rl_lo_r  :
        (a == tmr_pkg::OFF_RL_HI)   ? rl_hi_r  :
        (a == tmr_pkg::OFF_CLK_CTL) ? clk_view :
        (a == tmr_pkg::OFF_IRQ_EN)  ? {7'h00, irq_en_r} : 8'h00;

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_wrap_reload: assert property (
        wrap16 && !wr_cnt_lo && !wr_cnt_hi |=>
        {cnt_hi_r, cnt_lo_r} == $past({rl_hi_r, rl_lo_r}))
        else $error("16-bit overflow did not reload");

    a_wrap_flag: assert property (
        wrap16 |=> hi_flag_r)
        else $error("16-bit overflow left high flag clear");

    a_irq_full: assert property (
        wrap16 && irq_en_r && !wr_irq |=> irq_request)
        else $error("no interrupt after 16-bit overflow");

    a_irq_low: assert property (
        lo_wrap && irq_en_r && low_byte_irq_enable && !wr_ctl &&
        !wr_irq |=> irq_request)
        else $error("no interrupt after low byte wrap");

    a_split_reload: assert property (
        split && lo_wrap && !wr_cnt_lo |=> cnt_lo_r == $past(rl_lo_r))
        else $error("split low byte did not reload");

    a_low_free: assert property (
        split && !run_control && tick_lo && !lo_full && !wr_cnt_lo
        |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
        else $error("split low byte did not count");

    a_high_gated: assert property (
        split && !run_control && !wr_cnt_hi |=> $stable(cnt_hi_r))
        else $error("split high byte moved while stopped");

    a_system_clock_rate: assert property (
        split && low_clock_select && !wr_cnt_lo && !lo_full
        |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
        else $error("low byte not counting on every clock");

    a_split_flag: assert property (
        hi_wrap_s |=> hi_flag_r)
        else $error("split high wrap left flag clear");

    a_split_irq: assert property (
        hi_wrap_s && irq_en_r && !wr_irq |=> irq_request)
        else $error("no interrupt after split high wrap");

    a_flag_sticky: assert property (
        (hi_flag_r || lo_flag_r) && !wr_ctl ##1 !wr_ctl |->
        $stable({hi_flag_r, lo_flag_r}) || $rose(hi_flag_r) ||
        $rose(lo_flag_r))
        else $error("overflow flag cleared by hardware");

    a_capture: assert property (
        capture_evt |=> {rl_hi_r, rl_lo_r} ==
        $past({cnt_hi_r, cnt_lo_r}) && hi_flag_r)
        else $error("capture did not copy count");

    a_low_flag: assert property (
        lo_wrap |=> lo_flag_r)
        else $error("low wrap left low flag clear");

    a_stopped_hold: assert property (
        !split && !run_control && !wr_cnt_lo && !wr_cnt_hi &&
        !wr_ctl |=> $stable({cnt_hi_r, cnt_lo_r}) &&
        $stable({hi_flag_r, lo_flag_r}))
        else $error("stopped 16-bit timer changed state");
endmodule
`default_nettype wire

// File: tb/auto_reload_timer_with_capture_tb.sv
// bench for the auto-reload timer with capture
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timer_with_capture_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        ext_osc, awready, wready, bvalid, arready, rvalid, irq_request;
    logic [7:0]  awaddr, araddr, rd, lo, hi;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] cap_a, cap_b;
    int          miscompares, comparisons, osc_cnt;

    auto_reload_timer_with_capture i_auto_reload_timer_with_capture (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_osc(ext_osc), .irq_request(irq_request));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // oscillator with a period of 10 clocks, so /8 falls every 80
    always @(posedge aclk) begin
        osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
        if (osc_cnt == 4) ext_osc <= ~ext_osc;
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        if (n == 50) begin
            miscompares++;
            finish_test();
        end
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata[7:0];
        rsp = rresp;
        if (n == 50) begin
            miscompares++;
            finish_test();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input string nm,
                        input logic [7:0] e);
        logic [7:0] v;
        rd8(a, v);
        chk(nm, e, v);
    endtask

    // count gained by the low byte over gap clocks
    task automatic rate_chk(input logic [7:0] c, input int gap,
                            input logic [7:0] e);
        logic [7:0] v0, v1;
        wr(tmr_pkg::OFF_CONTROL, c);
        rd8(tmr_pkg::OFF_CNT_LO, v0);
        repeat (gap - 2) @(posedge aclk);
        rd8(tmr_pkg::OFF_CNT_LO, v1);
        chk("count_rate", e, v1 - v0);
    endtask

    // clear the capture flag, then wait for the next capture
    task automatic wait_cap(output logic [15:0] c);
        int n;
        wr(tmr_pkg::OFF_CONTROL, 8'h14);
        for (n = 0; n < 60; n++) begin
            rd8(tmr_pkg::OFF_CONTROL, rd);
            if (rd[7] === 1'b1) break;
        end
        if (n == 60) begin
            miscompares++;
            finish_test();
        end
        rd8(tmr_pkg::OFF_RL_LO, lo);
        rd8(tmr_pkg::OFF_RL_HI, hi);
        c = {hi, lo};
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
        bready = 1'b1; rready = 1'b1; wstrb = 4'h1; ext_osc = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; osc_cnt = 0;
        miscompares = 0; comparisons = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(tmr_pkg::OFF_CONTROL, "control", 8'h00);
        rchk(tmr_pkg::OFF_RL_HI, "reload_hi", 8'h00);
        rd8(8'h1C, rd);
        chk("rresp", {6'h0, tmr_pkg::RESP_SLVERR}, {6'h0, rsp});
        wr(8'h20, 8'h55);
        chk("bresp", {6'h0, tmr_pkg::RESP_SLVERR}, {6'h0, rsp});
        wr(tmr_pkg::OFF_RL_LO, 8'h34);
        wr(tmr_pkg::OFF_RL_HI, 8'h12);
        wr(tmr_pkg::OFF_CLK_CTL, 8'h40);
        wr(tmr_pkg::OFF_IRQ_EN, 8'h01);
        wr(tmr_pkg::OFF_CNT_LO, 8'hFE);
        wr(tmr_pkg::OFF_CNT_HI, 8'hFF);
        wr(tmr_pkg::OFF_CONTROL, 8'h04);
        repeat (3) @(posedge aclk);
        rchk(tmr_pkg::OFF_CONTROL, "control", 8'hC4);
        chk("irq", 8'h01, {7'h0, irq_request});
        rchk(tmr_pkg::OFF_CNT_HI, "count_hi", 8'h12);
        wr(tmr_pkg::OFF_CONTROL, 8'hC0);
        rd8(tmr_pkg::OFF_CNT_LO, rd);
        rchk(tmr_pkg::OFF_CNT_LO, "count_lo", rd);
        rchk(tmr_pkg::OFF_CONTROL, "control", 8'hC0);
        wr(tmr_pkg::OFF_CONTROL, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_request});
        wr(tmr_pkg::OFF_CNT_HI, 8'h50);
        wr(tmr_pkg::OFF_CNT_LO, 8'hF0);
        wr(tmr_pkg::OFF_CONTROL, 8'h08);
        repeat (40) @(posedge aclk);
        rchk(tmr_pkg::OFF_CONTROL, "control", 8'h48);
        rchk(tmr_pkg::OFF_CNT_HI, "count_hi", 8'h50);
        chk("irq", 8'h00, {7'h0, irq_request});
        wr(tmr_pkg::OFF_CONTROL, 8'h68);
        chk("irq", 8'h01, {7'h0, irq_request});
        rchk(tmr_pkg::OFF_CONTROL, "control", 8'h68);
        wr(tmr_pkg::OFF_CLK_CTL, 8'hC0);
        wr(tmr_pkg::OFF_CNT_HI, 8'hFD);
        wr(tmr_pkg::OFF_CONTROL, 8'h0C);
        repeat (3) @(posedge aclk);
        rd8(tmr_pkg::OFF_CONTROL, rd);
        chk("high_flag", 8'h80, rd & 8'h80);
        wr(tmr_pkg::OFF_CONTROL, 8'h00);
        wr(tmr_pkg::OFF_CLK_CTL, 8'h40);
        wr(tmr_pkg::OFF_CNT_LO, 8'h00);
        wr(tmr_pkg::OFF_CNT_HI, 8'h00);
        wait_cap(cap_a);
        wait_cap(cap_b);
        cap_b = cap_b - cap_a;
        chk("capture_lo", 8'h50, cap_b[7:0]);
        chk("capture_hi", 8'h00, cap_b[15:8]);
        wr(tmr_pkg::OFF_CLK_CTL, 8'h00);
        rate_chk(8'h05, 160, 8'h02);
        rate_chk(8'h04, 120, 8'h0A);
        finish_test();
    end
endmodule
`default_nettype wire
